/* File: hdl/pll_clock_control_unit.sv */
`timescale 1ns/1ps
`include "ccu_defs.svh"
module pll_clock_control_unit #(
  parameter int LOCK_CYCLES = `CCU_LOCK_CYCLES,
  parameter int AUX_TIMEOUT = `CCU_AUX_TIMEOUT
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        osc_clock,
  input  wire logic        aux_low_clock,
  input  wire logic        ext_irq_in,
  // Core events
  input  wire logic        wfi_exec,
  input  wire logic        halt_exec,
  input  wire logic        wake_event,
  input  wire logic        mem_wait,
  input  wire logic        bus_req,
  // Clock enables and status
  output logic             system_tick,
  output logic             peripheral_tick,
  output logic             core_tick,
  output logic             core_clock,
  output logic             pll_enable,
  output logic             osc_enable,
  output logic             irq_n,
  output logic             halt_reset_req,
  output logic             unit_off
);

  logic [7:0]     clock_mode;
  logic [7:0]     clock_control;
  logic [7:0]     pll_config;
  logic           osc_stop_enable;
  logic           slow16_n;
  logic           pll_clock_select;
  logic           aux_clock_active;
  ccu_pkg::mode_t mode;
  ccu_pkg::src_t  cur_src;
  ccu_pkg::src_t  next_src;
  logic           osc_s1, osc_s2, osc_s3;
  logic           aux_s1, aux_s2, aux_s3;
  logic           ext_s1, ext_s2;
  logic [15:0]    aux_gap;
  logic           aux_present;
  logic [5:0]     pll_acc;
  logic [5:0]     mult;
  logic [15:0]    lock_cnt;
  logic           pll_lock;
  logic           pll_on;
  logic           osc_run;
  logic           osc_tick, ref_tick, slow_tick, pll_raw, pll_tick, src_tick;
  logic           src_dead, switch_ok, core_in, core_pulse;
  logic           unit_event;
  logic           wr_en, rd_setup, addr_ok, cfg_wr;
  logic [7:0]     rd_data;
  logic [7:0]     wbyte;

  wire input_halver      = clock_mode[`CCU_HALVER_BIT];
  wire [2:0] core_prescale = clock_mode[`CCU_PRS_MSB:`CCU_PRS_LSB];
  wire irq_source_select = clock_control[`CCU_IRQSEL_BIT];
  wire halt_reset_enable = clock_control[`CCU_HALTRST_BIT];
  wire aux_clock_select  = clock_control[`CCU_AUXSEL_BIT];
  wire wait_clock_select = clock_control[`CCU_WAITSEL_BIT];
  wire lowpower_wait_en  = clock_control[`CCU_LPWAIT_BIT];
  wire [1:0] pll_mult_sel = pll_config[`CCU_MULT_MSB:`CCU_MULT_LSB];
  wire [2:0] pll_div_sel  = pll_config[`CCU_DIV_MSB:`CCU_DIV_LSB];
  wire lp_entry = (mode == ccu_pkg::MODE_RUN) && wfi_exec && lowpower_wait_en;

  // APB decode
  assign addr_ok  = (paddr[1:0] == 2'h0) &&
                    ((paddr[11:2] == {2'h0, `CCU_IDX_MODE}) || (paddr[11:2] == {2'h0, `CCU_IDX_CTRL}) ||
                     (paddr[11:2] == {2'h0, `CCU_IDX_FLAG}) || (paddr[11:2] == {2'h0, `CCU_IDX_PLL}));
  assign rd_setup = psel && !penable;
  assign wr_en    = psel && penable && pready && pwrite && !pslverr && pstrb[0];
  assign wbyte    = pwdata[7:0];
  assign cfg_wr   = wr_en && (paddr[11:2] == {2'h0, `CCU_IDX_PLL});

  always_comb
  begin
    rd_data = 8'h00;
    if (paddr[11:2] == {2'h0, `CCU_IDX_MODE})
      rd_data = clock_mode;
    else if (paddr[11:2] == {2'h0, `CCU_IDX_CTRL})
      rd_data = clock_control;
    else if (paddr[11:2] == {2'h0, `CCU_IDX_FLAG})
      rd_data = {3'h0, osc_stop_enable, slow16_n, aux_clock_active, pll_lock, pll_clock_select};
    else if (paddr[11:2] == {2'h0, `CCU_IDX_PLL})
      rd_data = pll_config;
  end

  // Zero-wait slave: answer in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= rd_setup;
      pslverr <= rd_setup && !addr_ok;
      if (rd_setup)
        prdata <= (addr_ok && !pwrite) ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_mode <= `CCU_MODE_RST;
    else if (wr_en && (paddr[11:2] == {2'h0, `CCU_IDX_MODE}))
      clock_mode <= wbyte;
  end

  // Hardware set of aux select on aux low-power wait wins over a software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_control <= `CCU_CTRL_RST;
    else
    begin
      if (wr_en && (paddr[11:2] == {2'h0, `CCU_IDX_CTRL}))
        clock_control <= wbyte & `CCU_CTRL_MASK;
      if (lp_entry && wait_clock_select && aux_present)
        clock_control[`CCU_AUXSEL_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pll_config <= `CCU_PLL_RST;
    else if (cfg_wr)
      pll_config <= wbyte & `CCU_PLL_MASK;
  end

  // Flag register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_stop_enable  <= 1'b0;
      slow16_n         <= `CCU_SLOW16_RST;
      pll_clock_select <= 1'b0;
    end
    else
    begin
      if (wr_en && (paddr[11:2] == {2'h0, `CCU_IDX_FLAG}))
      begin
        osc_stop_enable  <= wbyte[`CCU_OSCSTOP_BIT] && aux_clock_active;
        slow16_n         <= wbyte[`CCU_SLOW16_BIT];
        pll_clock_select <= wbyte[`CCU_PLLSEL_BIT];
      end
      if ((pll_div_sel == `CCU_DIV_OFF) || !osc_run || lp_entry || !slow16_n ||
          (cfg_wr && (wbyte[`CCU_DIV_MSB:`CCU_DIV_LSB] == `CCU_DIV_OFF)))
        pll_clock_select <= 1'b0;
    end
  end

  // Operating mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode           <= ccu_pkg::MODE_RUN;
      halt_reset_req <= 1'b0;
    end
    else
    begin
      halt_reset_req <= 1'b0;
      unique case (mode)
        ccu_pkg::MODE_RUN:
          if (halt_exec && halt_reset_enable)
            halt_reset_req <= 1'b1;
          else if (halt_exec)
            mode <= ccu_pkg::MODE_HALTED;
          else if (wfi_exec)
            mode <= lowpower_wait_en ? ccu_pkg::MODE_LP_WAIT : ccu_pkg::MODE_CORE_WAIT;
        ccu_pkg::MODE_CORE_WAIT, ccu_pkg::MODE_LP_WAIT:
          if (wake_event)
            mode <= ccu_pkg::MODE_RUN;
        ccu_pkg::MODE_HALTED:
          mode <= ccu_pkg::MODE_HALTED;
      endcase
    end
  end

  // Pin synchronisers, third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {osc_s1, osc_s2, osc_s3} <= 3'h0;
      {aux_s1, aux_s2, aux_s3} <= 3'h0;
      {ext_s1, ext_s2}         <= 2'h3;
    end
    else
    begin
      {osc_s1, osc_s2, osc_s3} <= {osc_clock, osc_s1, osc_s2};
      {aux_s1, aux_s2, aux_s3} <= {aux_low_clock, aux_s1, aux_s2};
      {ext_s1, ext_s2}         <= {ext_irq_in, ext_s1};
    end
  end

  // Aux clock presence: an edge seen within the timeout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_gap     <= 16'h0000;
      aux_present <= 1'b0;
    end
    else
    begin
      if (aux_s2 && !aux_s3)
        aux_gap <= 16'h0000;
      else if (aux_gap < 16'(AUX_TIMEOUT))
        aux_gap <= aux_gap + 16'h0001;
      aux_present <= aux_gap < 16'(AUX_TIMEOUT);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      aux_clock_active <= 1'b0;
    else
      aux_clock_active <= aux_clock_select && aux_present;
  end

  // Oscillator and PLL enables
  assign osc_run = (mode != ccu_pkg::MODE_HALTED) &&
                   !(aux_clock_active && (osc_stop_enable ||
                     ((mode == ccu_pkg::MODE_LP_WAIT) && wait_clock_select)));
  assign pll_on  = (pll_div_sel != `CCU_DIV_OFF) && slow16_n && osc_run &&
                   (mode != ccu_pkg::MODE_LP_WAIT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_enable <= 1'b1;
      pll_enable <= 1'b0;
      unit_off   <= 1'b0;
    end
    else
    begin
      osc_enable <= osc_run;
      pll_enable <= pll_on;
      unit_off   <= (mode == ccu_pkg::MODE_HALTED);
    end
  end

  // Reference and divide-by-16 paths
  assign osc_tick = osc_s2 && !osc_s3 && osc_enable;

  tick_divider #(.W(1)) u_halver (
    .pclk     (pclk),
    .presetn  (presetn),
    .in_tick  (osc_tick),
    .clear    (1'b0),
    .ratio_m1 (input_halver),
    .out_tick (ref_tick)
  );

  tick_divider #(.W(4)) u_slow16 (
    .pclk     (pclk),
    .presetn  (presetn),
    .in_tick  (ref_tick),
    .clear    (1'b0),
    .ratio_m1 (`CCU_DIV16_M1),
    .out_tick (slow_tick)
  );

  // PLL model: each ref edge adds mult output edges, drained one per pclk
  always_comb
  begin
    unique case (pll_mult_sel)
      2'h0: mult = `CCU_MULT_C00;
      2'h1: mult = `CCU_MULT_C01;
      2'h2: mult = `CCU_MULT_C10;
      2'h3: mult = `CCU_MULT_C11;
    endcase
  end

  assign pll_raw = pll_enable && (pll_acc != 6'h00);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pll_acc <= 6'h00;
    else if (!pll_enable)
      pll_acc <= 6'h00;
    else if (ref_tick)
      pll_acc <= (pll_acc > `CCU_ACC_MAX - mult) ? `CCU_ACC_MAX : 6'(pll_acc + mult - {5'h00, pll_raw});
    else if (pll_raw)
      pll_acc <= pll_acc - 6'h01;
  end

  tick_divider #(.W(3)) u_pll_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .in_tick  (pll_raw),
    .clear    (!pll_enable),
    .ratio_m1 (pll_div_sel),
    .out_tick (pll_tick)
  );

  // Lock timer restarts on any PLL reconfiguration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lock_cnt <= 16'h0000;
    else if (!pll_on || cfg_wr)
      lock_cnt <= 16'h0000;
    else if (lock_cnt < 16'(LOCK_CYCLES))
      lock_cnt <= lock_cnt + 16'h0001;
  end

  assign pll_lock = pll_enable && (lock_cnt >= 16'(LOCK_CYCLES));

  // Source selection, aux overrides, slow path overrides PLL
  always_comb
  begin
    if (aux_clock_active)
      next_src = ccu_pkg::SRC_AUX;
    else if (!slow16_n || (mode == ccu_pkg::MODE_LP_WAIT))
      next_src = ccu_pkg::SRC_SLOW;
    else if (pll_clock_select && pll_lock)
      next_src = ccu_pkg::SRC_PLL;
    else
      next_src = ccu_pkg::SRC_REF;
  end

  always_comb
  begin
    unique case (cur_src)
      ccu_pkg::SRC_REF:  src_tick = ref_tick;
      ccu_pkg::SRC_PLL:  src_tick = pll_tick;
      ccu_pkg::SRC_SLOW: src_tick = slow_tick;
      ccu_pkg::SRC_AUX:  src_tick = aux_s2 && !aux_s3;
    endcase
  end

  assign src_dead  = (cur_src == ccu_pkg::SRC_AUX) ? !aux_present :
                     (!osc_enable || ((cur_src == ccu_pkg::SRC_PLL) && !pll_enable));
  assign switch_ok = src_tick || src_dead;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_src <= ccu_pkg::SRC_REF;
    else if (switch_ok)
      cur_src <= next_src;
  end

  // Entering or leaving a slow source, or oscillator restart
  assign unit_event = (switch_ok && (cur_src != next_src) &&
                       ((cur_src == ccu_pkg::SRC_AUX || cur_src == ccu_pkg::SRC_SLOW) !=
                        (next_src == ccu_pkg::SRC_AUX || next_src == ccu_pkg::SRC_SLOW))) ||
                      (osc_run && !osc_enable);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_n <= 1'b1;
    else
      irq_n <= irq_source_select ? !unit_event : ext_s2;
  end

  // Core prescaler
  assign core_in = src_tick && (mode == ccu_pkg::MODE_RUN) && !mem_wait && !bus_req;

  tick_divider #(.W(3)) u_core_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .in_tick  (core_in),
    .clear    (1'b0),
    .ratio_m1 (core_prescale),
    .out_tick (core_pulse)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      system_tick     <= 1'b0;
      peripheral_tick <= 1'b0;
      core_tick       <= 1'b0;
      core_clock      <= 1'b1;
    end
    else
    begin
      system_tick     <= src_tick && (mode != ccu_pkg::MODE_HALTED);
      peripheral_tick <= src_tick && (mode != ccu_pkg::MODE_HALTED);
      core_tick       <= core_pulse;
      core_clock      <= !core_pulse;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_halt_plain;
    (mode == ccu_pkg::MODE_RUN) && halt_exec && !halt_reset_enable;
  endsequence

  sequence s_off_after;
    unit_off && !osc_enable ##1 !pll_enable;
  endsequence

  AST_PLL_OFF_CODE: assert property ((pll_div_sel == `CCU_DIV_OFF) |=> !pll_enable)
    else $error("PLL enabled with divider code 111");
  AST_LOCK_LOW: assert property (!pll_enable |-> !pll_lock)
    else $error("Lock flag set while PLL off");
  AST_SEL_CLEAR: assert property ((!slow16_n || lp_entry) |=> !pll_clock_select)
    else $error("PLL select not cleared");
  AST_CORE_HOLD: assert property ((mem_wait || bus_req) |=> core_clock && !core_tick)
    else $error("Core clock not held high");
  AST_CORE_WAIT: assert property ((mode == ccu_pkg::MODE_CORE_WAIT) |=> !core_tick)
    else $error("Core clock runs during wait");
  AST_HALT_RESET: assert property (((mode == ccu_pkg::MODE_RUN) && halt_exec && halt_reset_enable)
    |=> halt_reset_req ##1 !halt_reset_req)
    else $error("Halt reset request missing");
  AST_HALT_OFF: assert property (s_halt_plain |=> ##1 s_off_after)
    else $error("Halt did not stop the unit");
  AST_IRQ_FALL: assert property ((unit_event && irq_source_select) |=> !irq_n)
    else $error("Unit interrupt edge missing");
  AST_IRQ_ROUTE: assert property (!irq_source_select |=> (irq_n == $past(ext_s2)))
    else $error("External interrupt not passed");
  AST_GLITCH_FREE: assert property ((cur_src != $past(cur_src)) |-> $past(switch_ok))
    else $error("Source changed mid period");
  AST_OSC_STOP: assert property ((!aux_clock_active && (mode != ccu_pkg::MODE_HALTED)) |=> osc_enable)
    else $error("Oscillator stopped without aux clock");

endmodule

/* File: inc/ccu_defs.svh */
`ifndef CCU_DEFS_SVH
`define CCU_DEFS_SVH

// Register indexes; byte address is four times the index
`define CCU_IDX_MODE      8'heb
`define CCU_IDX_CTRL      8'hf0
`define CCU_IDX_FLAG      8'hf2
`define CCU_IDX_PLL       8'hf6

// Reset values
`define CCU_MODE_RST      8'he0
`define CCU_CTRL_RST      8'h00
`define CCU_PLL_RST       8'h07
`define CCU_SLOW16_RST    1'b1

// Writable masks
`define CCU_CTRL_MASK     8'h8f
`define CCU_PLL_MASK      8'h37

// clock_mode fields
`define CCU_HALVER_BIT    5
`define CCU_PRS_MSB       4
`define CCU_PRS_LSB       2

// clock_control fields
`define CCU_IRQSEL_BIT    7
`define CCU_HALTRST_BIT   3
`define CCU_AUXSEL_BIT    2
`define CCU_WAITSEL_BIT   1
`define CCU_LPWAIT_BIT    0

// Flag register fields
`define CCU_OSCSTOP_BIT   4
`define CCU_SLOW16_BIT    3
`define CCU_AUXACT_BIT    2
`define CCU_LOCK_BIT      1
`define CCU_PLLSEL_BIT    0

// pll_config fields
`define CCU_MULT_MSB      5
`define CCU_MULT_LSB      4
`define CCU_DIV_MSB       2
`define CCU_DIV_LSB       0
`define CCU_DIV_OFF       3'h7

// Multiplier factors by code
`define CCU_MULT_C00      6'h0a
`define CCU_MULT_C01      6'h06
`define CCU_MULT_C10      6'h0e
`define CCU_MULT_C11      6'h08
`define CCU_ACC_MAX       6'h3f

// Divide-by-16 path, timing defaults in pclk cycles
`define CCU_DIV16_M1      4'hf
`define CCU_LOCK_CYCLES   1024
`define CCU_AUX_TIMEOUT   64

`endif

/* File: inc/ccu_pkg.sv */
package ccu_pkg;

  typedef enum logic [1:0] {
    SRC_REF  = 2'h0,
    SRC_PLL  = 2'h1,
    SRC_SLOW = 2'h3,
    SRC_AUX  = 2'h2
  } src_t;

  typedef enum logic [1:0] {
    MODE_RUN       = 2'h0,
    MODE_CORE_WAIT = 2'h1,
    MODE_LP_WAIT   = 2'h3,
    MODE_HALTED    = 2'h2
  } mode_t;

endpackage

/* File: hdl/tick_divider.sv */
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Ticks
  input  wire logic         in_tick,
  input  wire logic         clear,
  input  wire logic [W-1:0] ratio_m1,
  output logic              out_tick
);

  logic [W-1:0] cnt;

  assign out_tick = in_tick && (cnt >= ratio_m1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= '0;
    else if (clear)
      cnt <= '0;
    else if (in_tick)
      cnt <= (cnt >= ratio_m1) ? '0 : W'(cnt + 1'b1);
  end

endmodule

/* File: verification/test_pll_clock_control_unit.sv */
`timescale 1ns/1ps
module test_pll_clock_control_unit;
  localparam logic [11:0] A_MODE = 12'h3ac;
  localparam logic [11:0] A_CTRL = 12'h3c0;
  localparam logic [11:0] A_FLAG = 12'h3c8;
  localparam logic [11:0] A_PLL  = 12'h3d8;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic        pready, pslverr, e, osc_clock, aux_low_clock, ext_irq_in;
  logic        wfi_exec, halt_exec, wake_event, mem_wait, bus_req, aux_run;
  logic        system_tick, peripheral_tick, core_tick, core_clock;
  logic        pll_enable, osc_enable, irq_n, halt_reset_req, unit_off;
  int          n_errors, compares, cyc, ns, nc, np, nl;
  int          mul [4] = '{10, 6, 14, 8};

  pll_clock_control_unit #(.LOCK_CYCLES(8), .AUX_TIMEOUT(64)) pll_clock_control_unit_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .osc_clock, .aux_low_clock, .ext_irq_in, .wfi_exec, .halt_exec, .wake_event,
    .mem_wait, .bus_req, .system_tick, .peripheral_tick, .core_tick, .core_clock,
    .pll_enable, .osc_enable, .irq_n, .halt_reset_req, .unit_off
  );

  always #25 pclk = ~pclk;
  // Oscillator at one eighth of pclk, aux at one fortieth
  always #200 osc_clock = ~osc_clock;
  always #1000 if (aux_run) aux_low_clock = ~aux_low_clock;

  task summarize;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      summarize;
    end
  end

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task near(input string nm, input int v, input int lo, input int hi);
    chk(nm, 32'(v >= lo && v <= hi), 32'h1);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input string nm, input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(nm, r, {24'h0, x});
  endtask

  // Counts ticks and low core_clock cycles over n cycles
  task cnt(input int n);
    ns = 0;
    nc = 0;
    np = 0;
    nl = 0;
    repeat (n)
    begin
      @(posedge pclk);
      ns += (system_tick === 1'b1);
      nc += (core_tick === 1'b1);
      np += (peripheral_tick === 1'b1);
      nl += (core_clock === 1'b0);
    end
  endtask

  task pulse(input int k);
    @(posedge pclk);
    wfi_exec   <= (k == 0);
    wake_event <= (k == 1);
    halt_exec  <= (k == 2);
    @(posedge pclk);
    {wfi_exec, wake_event, halt_exec} <= 3'h0;
  endtask

  task irq_low(input string nm);
    int i;
    i = 0;
    while (irq_n !== 1'b0 && i < 600)
    begin
      @(posedge pclk);
      i++;
    end
    chk(nm, 32'(irq_n), 32'h0);
  endtask

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, osc_clock, aux_low_clock, aux_run} = 8'h00;
    {wfi_exec, halt_exec, wake_event, mem_wait, bus_req} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ext_irq_in = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd("mode", A_MODE, 8'he0);
    rd("ctrl", A_CTRL, 8'h00);
    rd("flag", A_FLAG, 8'h08);
    rd("pll", A_PLL, 8'h07);
    apb(1'b0, 12'h3f0, 8'h00);
    chk("unmapped", {r[30:0], e}, 32'h1);
    cnt(320);
    near("ref_half", ns, 19, 21);
    wr(A_MODE, 8'hcc);
    cnt(320);
    near("ref_full", ns, 39, 41);
    near("core_div", nc, 9, 11);
    chk("core_low", nl, nc);
    chk("periph", np, ns);
    mem_wait <= 1'b1;
    @(posedge pclk);
    cnt(80);
    chk("mem_wait", nl + nc, 0);
    mem_wait <= 1'b0;
    bus_req <= 1'b1;
    cnt(80);
    chk("bus_req", nl + nc, 0);
    bus_req <= 1'b0;
    wr(A_MODE, 8'he0);
    wr(A_PLL, 8'h01);
    repeat (2) @(posedge pclk);
    chk("pll_on", 32'(pll_enable), 32'h1);
    rd("unlocked", A_FLAG, 8'h08);
    repeat (60) @(posedge pclk);
    rd("locked", A_FLAG, 8'h0a);
    wr(A_FLAG, 8'h09);
    for (int m = 0; m < 4; m++)
    begin
      wr(A_PLL, {2'h0, 2'(m), 4'h1});
      repeat (60) @(posedge pclk);
      cnt(320);
      near("pll_rate", ns, mul[m] * 10 - 3, mul[m] * 10 + 3);
    end
    rd("pll_sel", A_FLAG, 8'h0b);
    wr(A_PLL, 8'h07);
    repeat (2) @(posedge pclk);
    chk("pll_off", 32'(pll_enable), 32'h0);
    rd("sel_clr", A_FLAG, 8'h08);
    wr(A_CTRL, 8'h80);
    wr(A_FLAG, 8'h00);
    irq_low("irq_in");
    cnt(1024);
    near("slow", ns, 3, 5);
    wr(A_FLAG, 8'h08);
    irq_low("irq_out");
    pulse(0);
    @(posedge pclk);
    cnt(320);
    chk("wait_core", nc, 0);
    near("wait_sys", ns, 19, 21);
    pulse(1);
    wr(A_PLL, 8'h01);
    repeat (60) @(posedge pclk);
    wr(A_FLAG, 8'h09);
    wr(A_CTRL, 8'h81);
    pulse(0);
    irq_low("irq_lp");
    cnt(1024);
    chk("lp_pll", 32'(pll_enable), 32'h0);
    chk("lp_core", nc, 0);
    near("lp_slow", ns, 3, 5);
    rd("lp_flag", A_FLAG, 8'h08);
    pulse(1);
    wr(A_CTRL, 8'h00);
    ext_irq_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("ext_lo", 32'(irq_n), 32'h0);
    ext_irq_in <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("ext_hi", 32'(irq_n), 32'h1);
    wr(A_CTRL, 8'h04);
    repeat (100) @(posedge pclk);
    rd("no_aux", A_FLAG, 8'h0a);
    aux_run <= 1'b1;
    repeat (200) @(posedge pclk);
    rd("aux_on", A_FLAG, 8'h0e);
    cnt(400);
    near("aux_rate", ns, 9, 11);
    wr(A_CTRL, 8'h07);
    pulse(0);
    repeat (4) @(posedge pclk);
    chk("wfi_osc", 32'(osc_enable), 32'h0);
    pulse(1);
    repeat (20) @(posedge pclk);
    rd("aux_kept", A_FLAG, 8'h0e);
    wr(A_FLAG, 8'h1c);
    repeat (4) @(posedge pclk);
    chk("osc_stop", 32'(osc_enable), 32'h0);
    wr(A_CTRL, 8'hf8);
    rd("ctrl_mask", A_CTRL, 8'h88);
    pulse(2);
    #1;
    chk("halt_rst", 32'(halt_reset_req), 32'h1);
    wr(A_CTRL, 8'h00);
    pulse(2);
    repeat (3) @(posedge pclk);
    chk("halted", {unit_off, osc_enable, pll_enable}, 32'h4);
    cnt(100);
    chk("no_ticks", ns, 0);
    summarize;
  end
endmodule
